// [src/cis_map.svh]
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

// apb byte offsets
`define CIS_CFG0_OFS 8'h00
`define CIS_CFG1_OFS 8'h04
`define CIS_STAT_OFS 8'h08
`define CIS_PEND_OFS 8'h0C
`define CIS_MASK_OFS 8'h10

// reset values
`define CIS_CFG0_RST 32'h0000_0800
`define CIS_CFG1_RST 32'h0000_0000
`define CIS_MASK_RST 4'hF

// interrupt bit positions
`define CIS_IRQ_TLOW 0
`define CIS_IRQ_THIGH 1
`define CIS_IRQ_LOOP 2
`define CIS_IRQ_QUAL 3
`define CIS_IRQ_W 4

// input quality codes
`define CIS_QUAL_UVLO 2'h0
`define CIS_QUAL_OVP 2'h1
`define CIS_QUAL_WAIT 2'h2
`define CIS_QUAL_OK 2'h3

// timing
`define CIS_CLK_HZ 40000000
`define CIS_CIN_DB_MS 120
`define CIS_CIN_DB_CYC ((`CIS_CLK_HZ / 1000) * `CIS_CIN_DB_MS)
`define CIS_PIN_DB_CYC 1024

`endif

// [src/cis_pkg.sv]
package cis_pkg;

  typedef enum logic [1:0] {
    CIS_OT_RUN = 2'b01,
    CIS_OT_LOCK = 2'b10
  } cis_ot_state_t;

  typedef struct packed {
    logic gin_as_input;
    logic charger_enable_bit;
    logic [4:0] system_voltage_target_sel;
    logic [2:0] input_current_limit_sel;
    logic [2:0] input_voltage_floor_sel;
  } cis_cfg0_t;

  typedef struct packed {
    logic [2:0] topoff_timer_sel;
    logic [1:0] fast_charge_timer_sel;
    logic [2:0] die_temp_limit_sel;
    logic [1:0] term_current_sel;
    logic precharge_current_sel;
    logic [2:0] precharge_threshold_sel;
    logic [5:0] charge_current_sel;
    logic [5:0] charge_voltage_sel;
  } cis_cfg1_t;

  typedef struct packed {
    logic temp_alarm_low_status;
    logic temp_alarm_high_status;
    logic input_limit_active;
    logic input_voltage_loop_active;
    logic [1:0] input_quality_field;
    logic overtemp_lockout;
  } cis_stat_t;

endpackage

// [src/cis_charger_input_status.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cis_map.svh"

// How it works
// RULE_01 - power-on, charge input and general input pins debounced on both edges
// RULE_02 - debounced output follows only after a full stable interval; glitches restart it
// RULE_03 - low and high junction alarm status bits track their comparators continuously
// RULE_04 - any change of either alarm bit latches a maskable interrupt
// RULE_05 - overtemperature while on shuts every resource down at once
// RULE_06 - after lockout, resources stay blocked until the die cools 15C below threshold
// RULE_07 - input current limit status follows the loop; engaging raises loop interrupt
// RULE_08 - input overvoltage or undervoltage keeps charger off, battery feeds system
// RULE_09 - power delivery starts only 120ms after a valid source appears
// RULE_10 - 2-bit input quality field; any change raises quality interrupt
// RULE_11 - input voltage loop status; engaging raises the same loop interrupt
// RULE_12 - software selectors for all charger settings live in config registers
// RULE_13 - input overvoltage, undervoltage and precharge timer have no setting
// RULE_14 - minimum system voltage setpoint follows the system voltage target
// RULE_15 - battery off system while input powers it, on system without input
// RULE_16 - cleared charger enable bit stops charging regardless of input
// RULE_17 - interrupts latch on change and reach the output only when unmasked
// RULE_18 - pin debounce intervals are module parameters
module cis_charger_input_status import cis_pkg::*; #(
  parameter int unsigned PON_DB_CYC = `CIS_PIN_DB_CYC,
  parameter int unsigned GIN_DB_CYC = `CIS_PIN_DB_CYC,
  parameter int unsigned CIN_DB_CYC = `CIS_CIN_DB_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic power_on_request_pin_in,
  input wire logic general_input_pin_in,
  input wire logic charge_input_pin_in,
  input wire logic tj_above_low_in,
  input wire logic tj_above_high_in,
  input wire logic tj_above_lockout_in,
  input wire logic tj_cooled_in,
  input wire logic device_on_in,
  input wire logic input_ovp_in,
  input wire logic input_uvlo_in,
  input wire logic input_limit_loop_in,
  input wire logic input_voltage_loop_in,
  output logic power_on_request_out,
  output logic general_input_out,
  output logic charge_input_out,
  output logic resources_shutdown_out,
  output logic input_power_deliver_out,
  output logic charger_on_out,
  output logic battery_to_system_out,
  output cis_cfg0_t cfg0_out,
  output cis_cfg1_t cfg1_out,
  output logic [4:0] system_min_target_out,
  output logic irq_out
);

  localparam int CW = 24;

  // debounce limit per channel: 0 power-on, 1 general input, 2 charge input
  function automatic logic [CW-1:0] db_limit(input int idx);
    case (idx)
      0: db_limit = CW'(PON_DB_CYC - 1);
      1: db_limit = CW'(GIN_DB_CYC - 1);
      default: db_limit = CW'(CIN_DB_CYC - 1);
    endcase
  endfunction

  cis_cfg0_t cfg0_q;
  cis_cfg1_t cfg1_q;
  cis_stat_t stat_q;
  cis_ot_state_t ot_q;
  logic [2:0] raw;
  logic [2:0] db_q;
  logic [CW-1:0] cnt_q [3];
  logic [`CIS_IRQ_W-1:0] pend_q;
  logic [`CIS_IRQ_W-1:0] mask_q;
  logic [`CIS_IRQ_W-1:0] event_d;
  logic [1:0] qual_d;
  logic input_ok_d;
  logic wr_ok;
  logic [31:0] rd_d;
  logic rd_hit;

  // pins are taken as synchronous, so no extra flop stage sits in front of the counters
  assign raw = {charge_input_pin_in, general_input_pin_in, power_on_request_pin_in};

  // both edges: counter runs while raw differs from output, restarts on any glitch
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      db_q <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (raw[i] == db_q[i]) begin // [RULE_02]
          cnt_q[i] <= '0;
        end else if (cnt_q[i] >= db_limit(i)) begin // [RULE_01] [RULE_18]
          db_q[i] <= raw[i];
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + CW'(1);
        end
      end
    end
  end

  // general input pin only reaches general_input_out when configured as an input; the status register shows it always
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      power_on_request_out <= 1'b0;
      general_input_out <= 1'b0;
      charge_input_out <= 1'b0;
    end else begin
      power_on_request_out <= db_q[0];
      general_input_out <= db_q[1] & cfg0_q.gin_as_input; // [RULE_01]
      charge_input_out <= db_q[2];
    end
  end

  // fixed thresholds arrive as comparator levels; nothing here is programmable [RULE_13]
  always_comb begin
    if (input_uvlo_in) qual_d = `CIS_QUAL_UVLO;
    else if (input_ovp_in) qual_d = `CIS_QUAL_OVP;
    else if (!db_q[2]) qual_d = `CIS_QUAL_WAIT; // [RULE_09]
    else qual_d = `CIS_QUAL_OK;
  end
  assign input_ok_d = (qual_d == `CIS_QUAL_OK);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stat_q <= '0;
    end else begin
      stat_q.temp_alarm_low_status <= tj_above_low_in; // [RULE_03]
      stat_q.temp_alarm_high_status <= tj_above_high_in; // [RULE_03]
      stat_q.input_limit_active <= input_limit_loop_in; // [RULE_07]
      stat_q.input_voltage_loop_active <= input_voltage_loop_in; // [RULE_11]
      stat_q.input_quality_field <= qual_d; // [RULE_10]
      stat_q.overtemp_lockout <= (ot_q == CIS_OT_LOCK);
    end
  end

  // lockout bypasses the sequenced power-down; cooling is the only way out
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ot_q <= CIS_OT_RUN;
    end else begin
      case (ot_q)
        CIS_OT_RUN: if (tj_above_lockout_in && device_on_in) ot_q <= CIS_OT_LOCK; // [RULE_05]
        CIS_OT_LOCK: if (tj_cooled_in) ot_q <= CIS_OT_RUN; // [RULE_06]
        default: ot_q <= CIS_OT_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      resources_shutdown_out <= 1'b0;
      input_power_deliver_out <= 1'b0;
      charger_on_out <= 1'b0;
      battery_to_system_out <= 1'b1;
    end else begin
      resources_shutdown_out <= (ot_q == CIS_OT_LOCK) ||
                                (tj_above_lockout_in && device_on_in); // [RULE_05] [RULE_06]
      input_power_deliver_out <= input_ok_d; // [RULE_08] [RULE_09]
      charger_on_out <= input_ok_d && cfg0_q.charger_enable_bit; // [RULE_08] [RULE_16]
      battery_to_system_out <= !input_ok_d; // [RULE_15]
    end
  end

  assign event_d[`CIS_IRQ_TLOW] = stat_q.temp_alarm_low_status != tj_above_low_in; // [RULE_04]
  assign event_d[`CIS_IRQ_THIGH] = stat_q.temp_alarm_high_status != tj_above_high_in; // [RULE_04]
  assign event_d[`CIS_IRQ_LOOP] = (input_limit_loop_in && !stat_q.input_limit_active) ||
      (input_voltage_loop_in && !stat_q.input_voltage_loop_active); // [RULE_07] [RULE_11]
  assign event_d[`CIS_IRQ_QUAL] = stat_q.input_quality_field != qual_d; // [RULE_10]

  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

  // write-one-to-clear; a new event in the same cycle keeps the bit set
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend_q <= '0;
    end else if (wr_ok && paddr_in == `CIS_PEND_OFS) begin
      pend_q <= (pend_q & ~pwdata_in[`CIS_IRQ_W-1:0]) | event_d; // [RULE_17]
    end else begin
      pend_q <= pend_q | event_d; // [RULE_17]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) irq_out <= 1'b0;
    else irq_out <= |(pend_q & ~mask_q); // [RULE_17]
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg0_q <= cis_cfg0_t'(`CIS_CFG0_RST);
      cfg1_q <= cis_cfg1_t'(`CIS_CFG1_RST);
      mask_q <= `CIS_MASK_RST;
    end else if (wr_ok) begin
      case (paddr_in)
        `CIS_CFG0_OFS: cfg0_q <= cis_cfg0_t'(pwdata_in[$bits(cis_cfg0_t)-1:0]); // [RULE_12]
        `CIS_CFG1_OFS: cfg1_q <= cis_cfg1_t'(pwdata_in[$bits(cis_cfg1_t)-1:0]); // [RULE_12]
        `CIS_MASK_OFS: mask_q <= pwdata_in[`CIS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg0_out <= cis_cfg0_t'(`CIS_CFG0_RST);
      cfg1_out <= cis_cfg1_t'(`CIS_CFG1_RST);
      system_min_target_out <= 5'h00;
    end else begin
      cfg0_out <= cfg0_q;
      cfg1_out <= cfg1_q;
      system_min_target_out <= cfg0_q.system_voltage_target_sel; // [RULE_14]
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_in)
      `CIS_CFG0_OFS: rd_d = 32'(cfg0_q);
      `CIS_CFG1_OFS: rd_d = 32'(cfg1_q);
      `CIS_STAT_OFS: rd_d = {22'h0, db_q, stat_q};
      `CIS_PEND_OFS: rd_d = 32'(pend_q);
      `CIS_MASK_OFS: rd_d = 32'(mask_q);
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait-free access cycle: answer is prepared in the setup cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in && !penable_in;
      if (psel_in && !penable_in) begin
        pslverr_out <= !rd_hit;
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_d;
      end else begin
        pslverr_out <= 1'b0;
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  deb_glitch_a: assert property ($changed(db_q[0]) |-> $past(raw[0], 1) == db_q[0] && // [RULE_02]
      $past(cnt_q[0]) == db_limit(0))
    else $error("power-on debounce changed without a full stable interval");
  deb_chg_edge_a: assert property (raw[2] != db_q[2] && raw[2] == $past(raw[2]) && // [RULE_01]
      cnt_q[2] >= db_limit(2) |=> db_q[2] == $past(raw[2]))
    else $error("charge input debounce missed an edge");
  temp_track_a: assert property (##1 // [RULE_03]
      stat_q.temp_alarm_high_status == $past(tj_above_high_in))
    else $error("high alarm status does not track comparator");
  temp_irq_a: assert property ($changed(stat_q.temp_alarm_low_status) |-> // [RULE_04]
      pend_q[`CIS_IRQ_TLOW])
    else $error("low alarm change did not latch interrupt");
  lock_shut_a: assert property (tj_above_lockout_in && device_on_in |=> // [RULE_05]
      resources_shutdown_out ##1 ot_q == CIS_OT_LOCK || $past(tj_cooled_in))
    else $error("overtemperature did not shut resources down");
  lock_hold_a: assert property (ot_q == CIS_OT_LOCK && !tj_cooled_in |=> // [RULE_06]
      ot_q == CIS_OT_LOCK ##1 resources_shutdown_out)
    else $error("lockout released before cooling");
  loop_irq_a: assert property ($rose(input_voltage_loop_in) |=> pend_q[`CIS_IRQ_LOOP]) // [RULE_11]
    else $error("voltage loop engage did not raise loop interrupt");
  ovp_off_a: assert property (input_ovp_in |=> !charger_on_out && // [RULE_08]
      !input_power_deliver_out && battery_to_system_out)
    else $error("charger active during input overvoltage");
  qual_irq_a: assert property ($changed(stat_q.input_quality_field) |-> // [RULE_10]
      pend_q[`CIS_IRQ_QUAL])
    else $error("quality change did not latch interrupt");
  charger_off_a: assert property (!cfg0_q.charger_enable_bit |=> !charger_on_out) // [RULE_16]
    else $error("charger on while disabled");
  irq_gate_a: assert property (##1 irq_out == |($past(pend_q) & ~$past(mask_q))) // [RULE_17]
    else $error("interrupt output not gated by mask");

  limit_stat_a: assert property (##1 // [RULE_07]
      stat_q.input_limit_active == $past(input_limit_loop_in))
    else $error("limit status does not track the current loop");
  limit_irq_a: assert property ($rose(input_limit_loop_in) |=> // [RULE_07]
      pend_q[`CIS_IRQ_LOOP])
    else $error("current limit engage did not raise loop interrupt");
  vloop_stat_a: assert property (##1 // [RULE_11]
      stat_q.input_voltage_loop_active == $past(input_voltage_loop_in))
    else $error("voltage loop status does not track the loop");
  low_track_a: assert property (##1 // [RULE_03]
      stat_q.temp_alarm_low_status == $past(tj_above_low_in))
    else $error("low alarm status does not track comparator");
  high_irq_a: assert property ($changed(stat_q.temp_alarm_high_status) |-> // [RULE_04]
      pend_q[`CIS_IRQ_THIGH])
    else $error("high alarm change did not latch interrupt");
  uvlo_off_a: assert property (input_uvlo_in |=> !charger_on_out && // [RULE_08]
      !input_power_deliver_out && battery_to_system_out)
    else $error("charger active during input undervoltage");
  wait_power_a: assert property (!db_q[2] |=> !input_power_deliver_out && // [RULE_09]
      !charger_on_out)
    else $error("power delivered before the charge input settled");
  batt_path_a: assert property (battery_to_system_out != // [RULE_15]
      input_power_deliver_out)
    else $error("battery and input both or neither feed the system");
  min_track_a: assert property (##1 // [RULE_14]
      system_min_target_out == $past(cfg0_q.system_voltage_target_sel))
    else $error("minimum system target does not follow the target");
  ovp_code_a: assert property (input_ovp_in && !input_uvlo_in |=> // [RULE_10]
      stat_q.input_quality_field == `CIS_QUAL_OVP)
    else $error("overvoltage not reported in quality field");
  deb_restart_a: assert property (raw[1] == db_q[1] |=> // [RULE_02]
      cnt_q[1] == '0)
    else $error("general input debounce did not restart");
  gin_gate_a: assert property (!cfg0_q.gin_as_input |=> // [RULE_01]
      !general_input_out)
    else $error("general input reported while not an input");
  cfg_write_a: assert property (wr_ok && paddr_in == `CIS_CFG1_OFS |=> // [RULE_12]
      cfg1_q == cis_cfg1_t'($past(pwdata_in[$bits(cis_cfg1_t)-1:0])))
    else $error("charge settings write did not land");
  pend_sticky_a: assert property (pend_q[`CIS_IRQ_QUAL] && // [RULE_17]
      !(wr_ok && paddr_in == `CIS_PEND_OFS) |=> pend_q[`CIS_IRQ_QUAL])
    else $error("quality interrupt dropped without a clear");
  lock_down_a: assert property (ot_q == CIS_OT_LOCK |=> // [RULE_06]
      resources_shutdown_out)
    else $error("resources enabled during lockout");

  lockout_seen_c: cover property (ot_q == CIS_OT_LOCK ##[1:20] ot_q == CIS_OT_RUN);
  deliver_rise_c: cover property ($rose(input_power_deliver_out));
  pend_clear_c: cover property (wr_ok && paddr_in == `CIS_PEND_OFS ##1 pend_q == '0);
  irq_fire_c: cover property ($rose(irq_out));
  qual_ready_c: cover property (stat_q.input_quality_field == `CIS_QUAL_WAIT ##1
      stat_q.input_quality_field == `CIS_QUAL_OK);

endmodule // cis_charger_input_status

`default_nettype wire

// [sim/cis_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_source_model (
  input wire logic clk_in,
  input wire logic plug_in,
  input wire logic [1:0] mode_in,
  output logic pin_out,
  output logic ovp_out,
  output logic uvlo_out
);
  // comparators settle one edge after the source moves; unplugged reads as undervoltage
  always_ff @(posedge clk_in) begin
    pin_out <= plug_in;
    ovp_out <= plug_in && mode_in == 2'h1;
    uvlo_out <= !plug_in || mode_in == 2'h2;
  end
endmodule // cis_source_model
`default_nettype wire

// [sim/tb_charger_input_status.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cis_map.svh"
module tb_charger_input_status;
  import cis_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [2:0] raw = 3'h0;
  logic [1:0] mode = 2'h0;
  logic tlo = 1'b0, thi = 1'b0, tlock = 1'b0, tcool = 1'b0;
  logic don = 1'b0, lim = 1'b0, vlp = 1'b0;
  logic chg_pin, ovp, uvlo, pon_o, gin_o, chg_o, shut, deliver, chg_on, batt, irq;
  wire logic [2:0] outs = {chg_o, gin_o, pon_o};
  cis_cfg0_t cfg0;
  cis_cfg1_t cfg1;
  logic [4:0] smin;
  int miscompares = 0;
  int tests_run = 0;
  always #12.5 clk_in = ~clk_in;
  cis_source_model src (.clk_in(clk_in), .plug_in(raw[2]), .mode_in(mode), .pin_out(chg_pin),
    .ovp_out(ovp), .uvlo_out(uvlo));
  cis_charger_input_status #(.PON_DB_CYC(8), .GIN_DB_CYC(8), .CIN_DB_CYC(8)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .power_on_request_pin_in(raw[0]),
    .general_input_pin_in(raw[1]), .charge_input_pin_in(chg_pin), .tj_above_low_in(tlo),
    .tj_above_high_in(thi), .tj_above_lockout_in(tlock), .tj_cooled_in(tcool),
    .device_on_in(don), .input_ovp_in(ovp), .input_uvlo_in(uvlo),
    .input_limit_loop_in(lim), .input_voltage_loop_in(vlp),
    .power_on_request_out(pon_o), .general_input_out(gin_o), .charge_input_out(chg_o),
    .resources_shutdown_out(shut), .input_power_deliver_out(deliver),
    .charger_on_out(chg_on), .battery_to_system_out(batt), .cfg0_out(cfg0),
    .cfg1_out(cfg1), .system_min_target_out(smin), .irq_out(irq));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // request held until the edge where pready is seen high; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(r, exp, what);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    miscompares++;
    $display("MISMATCH %0t watchdog timeout", $time);
    wrap_up;
  end
  initial begin
    cyc(12);
    reset_in <= 1'b0;
    rd(`CIS_CFG0_OFS, `CIS_CFG0_RST, "cfg0 rst");
    rd(`CIS_CFG1_OFS, `CIS_CFG1_RST, "cfg1 rst");
    rd(`CIS_MASK_OFS, 32'h0000_000F, "mask rst");
    chk({shut, deliver, chg_on, batt, irq}, 5'b00010, "reset outs");
    apb(1'b1, `CIS_CFG0_OFS, 32'h0000_1D6A);
    apb(1'b1, `CIS_CFG1_OFS, 32'h02AA_AAAA);
    rd(`CIS_CFG0_OFS, 32'h0000_1D6A, "cfg0 rw");
    rd(`CIS_CFG1_OFS, 32'h02AA_AAAA, "cfg1 rw");
    chk(cfg0, 13'h1D6A, "cfg0 out");
    chk(cfg1, 26'h2AA_AAAA, "cfg1 out");
    chk(smin, 5'h15, "min target");
    rd(8'h14, 32'h0, "unmapped");
    chk(e, 1'b1, "slverr");
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      raw[i] <= 1'b1;
      cyc(4);
      raw[i] <= 1'b0;
      cyc(14);
      chk(outs[i], 1'b0, "rise glitch");
      raw[i] <= 1'b1;
      cyc(14);
      chk(outs[i], 1'b1, "rise");
      raw[i] <= 1'b0;
      cyc(4);
      raw[i] <= 1'b1;
      cyc(14);
      chk(outs[i], 1'b1, "fall glitch");
      raw[i] <= 1'b0;
      cyc(14);
      chk(outs[i], 1'b0, "fall");
    end
    $display("test debounce done");
    raw[2] <= 1'b1;
    cyc(4);
    chk(deliver, 1'b0, "early power");
    apb(1'b0, `CIS_STAT_OFS, 32'h0);
    chk(r[2:1], `CIS_QUAL_WAIT, "wait code");
    cyc(10);
    chk({deliver, chg_on, batt}, 3'b110, "powered");
    mode <= 2'h1;
    cyc(4);
    chk({deliver, chg_on, batt}, 3'b001, "ovp");
    apb(1'b0, `CIS_STAT_OFS, 32'h0);
    chk(r[2:1], `CIS_QUAL_OVP, "ovp code");
    mode <= 2'h0;
    cyc(20);
    chk(deliver, 1'b1, "recover");
    apb(1'b1, `CIS_CFG0_OFS, 32'h0000_156A);
    cyc(3);
    chk({deliver, chg_on}, 2'b10, "disabled");
    $display("test power path done");
    apb(1'b1, `CIS_PEND_OFS, 32'hF);
    apb(1'b1, `CIS_MASK_OFS, 32'h0);
    cyc(3);
    chk(irq, 1'b0, "irq idle");
    tlo <= 1'b1;
    cyc(4);
    chk(irq, 1'b1, "irq low");
    rd(`CIS_PEND_OFS, 32'h1, "pend low");
    apb(1'b1, `CIS_PEND_OFS, 32'h1);
    apb(1'b1, `CIS_MASK_OFS, 32'h2);
    thi <= 1'b1;
    cyc(4);
    chk(irq, 1'b0, "masked");
    rd(`CIS_PEND_OFS, 32'h2, "pend high");
    apb(1'b0, `CIS_STAT_OFS, 32'h0);
    chk(r[6:5], 2'b11, "alarms");
    apb(1'b1, `CIS_PEND_OFS, 32'h2);
    lim <= 1'b1;
    cyc(4);
    rd(`CIS_PEND_OFS, 32'h4, "pend limit");
    apb(1'b1, `CIS_PEND_OFS, 32'h4);
    lim <= 1'b0;
    vlp <= 1'b1;
    cyc(4);
    rd(`CIS_PEND_OFS, 32'h4, "pend vloop");
    apb(1'b0, `CIS_STAT_OFS, 32'h0);
    chk(r[4:3], 2'b01, "loop stat");
    apb(1'b1, `CIS_PEND_OFS, 32'h4);
    mode <= 2'h2;
    cyc(4);
    rd(`CIS_PEND_OFS, 32'h8, "pend qual");
    apb(1'b0, `CIS_STAT_OFS, 32'h0);
    chk(r[2:1], `CIS_QUAL_UVLO, "uvlo code");
    chk({deliver, chg_on, batt}, 3'b001, "uvlo");
    $display("test interrupts done");
    don <= 1'b1;
    tlock <= 1'b1;
    cyc(3);
    chk(shut, 1'b1, "lockout");
    tlock <= 1'b0;
    cyc(5);
    chk(shut, 1'b1, "hold off");
    tcool <= 1'b1;
    cyc(5);
    chk(shut, 1'b0, "cooled");
    $display("test lockout done");
    wrap_up;
  end
endmodule // tb_charger_input_status
`default_nettype wire
